// file: common/bcf_pkg.sv
// Constants, field layout and state type for the buck channel control block
package bcf_pkg;
  // Timing, clock is 20 MHz
  localparam int SYS_PERIOD_NS = 50;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = US_NS / SYS_PERIOD_NS;
  localparam int MIN_ON_NS     = 40;
  localparam int MIN_ON_CYC    = (MIN_ON_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int DLY_STEP_US   = 250;
  localparam int OC_RESTART_MS = 200;
  localparam int OC_RESTART_US = OC_RESTART_MS * 1000;
  localparam int SAMPLE_CYC    = 16;

  // current_limit_and_warning fields, 5 mV per code
  localparam int ILIM_LIM_LSB    = 0;
  localparam int ILIM_LIM_W      = 6;
  localparam int ILIM_MARGIN_LSB = 6;
  localparam int ILIM_MARGIN_W   = 2;
  localparam int MARGIN_STEP     = 2;

  // soft_start_delay_ramp and soft_stop_delay_ramp fields
  localparam int RAMP_DLY_LSB  = 10;
  localparam int RAMP_DLY_W    = 6;
  localparam int RAMP_STEP_LSB = 0;
  localparam int RAMP_STEP_W   = 10;

  // switching_frequency_select fields
  localparam int FREQ_OSC_LSB = 4;
  localparam int FREQ_DIV_LSB = 0;
  localparam int FREQ_SEL_W   = 3;
  localparam int OSC_BASE_KHZ = 48000;
  localparam int OSC_STEP_KHZ = 3200;
  localparam int OSC_PER_DIV  = 16;
  localparam int PWM_MIN_KHZ  = 300;

  // Reset values and thresholds
  localparam logic [7:0] REF_RST    = 8'h00;
  localparam logic [7:0] DISCH_REF  = 8'h00;
  localparam logic [2:0] DIV_ILLEGAL = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF, ST_SS_DLY, ST_SS_RAMP, ST_ON, ST_SD_DLY, ST_SD_RAMP, ST_OC_WAIT
  } bcf_state_t;
endpackage : bcf_pkg

// file: rtl/bcf_ctrl.sv
// Fault, soft-start/stop, power-good and PWM timing for the buck channels
//
// Contract
// - OV trip disables channel and followers, latched
// - Any fault or warning routable to GPIO
// - OV shutdown: passive stops pulses, forced holds low-side
// - Current ADC compared to limit and warning
// - Limit code bits 5:0, 5 mV step
// - Margin bits 7:6: 10 to 40 mV below
// - Warning follows current, clears by itself
// - OC stops drive, waits 200 ms, soft-starts
// - OC restarts followers, sets fault flag
// - Soft-start delay bits 15:10, 250 us steps
// - Soft-start ramp microseconds per 50 mV step
// - Soft-stop delay bits 15:10, 250 us steps
// - Soft-stop ramp microseconds per 50 mV step
// - Power-good high inside 20 mV window
// - Power-good delay starts after soft-start ends
// - Oscillator code selects 48 to 25.6 MHz
// - Divider code zero and sub-300 kHz invalid
// - Minimum high-side on time 40 ns
// - OV detection active always, sets fault bit
// - Sixteen oscillator cycles low-side each period
`timescale 1ns/1ps
module bcf_ctrl #(
  parameter int NCH           = 4,
  parameter int OC_RESTART_US = bcf_pkg::OC_RESTART_US
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  input  wire logic [NCH-1:0]     CH_EN,
  input  wire logic [NCH*8-1:0]   ILIM_CFG,
  input  wire logic [NCH*16-1:0]  SS_CFG,
  input  wire logic [NCH*16-1:0]  SD_CFG,
  input  wire logic [7:0]         FREQ_CFG,
  input  wire logic [NCH*8-1:0]   VOUT_TARGET,
  input  wire logic [NCH*8-1:0]   PG_MAX,
  input  wire logic [NCH*8-1:0]   PG_MIN,
  input  wire logic [NCH*8-1:0]   PG_DLY,
  input  wire logic [NCH*NCH-1:0] FOLLOW,
  input  wire logic [NCH-1:0]     OV_FORCED,
  input  wire logic [NCH*3-1:0]   GPIO_MAP,
  input  wire logic [NCH-1:0]     OV_TRIP,
  input  wire logic [NCH*8-1:0]   ISENSE,
  input  wire logic [NCH*8-1:0]   VOUT_ADC,
  input  wire logic [NCH*8-1:0]   DUTY,
  input  wire logic [NCH-1:0]     OC_CLR,
  input  wire logic [NCH-1:0]     OV_CLR,
  output logic      [NCH-1:0]     GATE_HI,
  output logic      [NCH-1:0]     GATE_LO,
  output logic      [NCH*8-1:0]   REF_CODE,
  output logic      [NCH-1:0]     PGOOD,
  output logic      [NCH-1:0]     OC_FAULT,
  output logic      [NCH-1:0]     OV_FAULT,
  output logic      [NCH-1:0]     OC_WARN,
  output logic                    FAULT_GPIO,
  output logic      [15:0]        OSC_KHZ,
  output logic                    FREQ_BAD
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  bcf_pkg::bcf_state_t st [NCH];
  logic [17:0]         cnt [NCH];
  logic [17:0]         pg_cnt [NCH];
  logic [NCH-1:0]      ov_s1;
  logic [NCH-1:0]      ov_s2;
  logic [NCH-1:0]      ov_lock;
  logic [NCH-1:0]      ov_kill;
  logic [NCH-1:0]      oc_now;
  logic [NCH-1:0]      oc_kill;
  logic [NCH-1:0]      running;
  logic [4:0]          pre;
  logic                us_tick;
  logic [7:0]          pcnt;
  logic [7:0]          period;
  logic [2:0]          osc_code;
  logic [2:0]          div_code;
  logic [15:0]         next_osc_khz;
  logic                next_freq_bad;
  logic [NCH*3-1:0]    status;

  assign osc_code = FREQ_CFG[bcf_pkg::FREQ_OSC_LSB +: bcf_pkg::FREQ_SEL_W];
  assign div_code = FREQ_CFG[bcf_pkg::FREQ_DIV_LSB +: bcf_pkg::FREQ_SEL_W];
  assign period   = 8'({div_code, 4'h0}) + 8'(bcf_pkg::OSC_PER_DIV);
  assign status   = {OC_WARN, OC_FAULT, OV_FAULT};

  // Oscillator and divider decode
  always_comb begin
    next_osc_khz  = 16'(bcf_pkg::OSC_BASE_KHZ) - 16'(bcf_pkg::OSC_STEP_KHZ * osc_code);
    next_freq_bad = (div_code == bcf_pkg::DIV_ILLEGAL) ||
                    (next_osc_khz < 16'(bcf_pkg::PWM_MIN_KHZ * bcf_pkg::OSC_PER_DIV *
                                        (div_code + 1)));
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      OSC_KHZ  <= 16'(bcf_pkg::OSC_BASE_KHZ);
      FREQ_BAD <= 1'b1;
    end else begin
      OSC_KHZ  <= next_osc_khz;
      FREQ_BAD <= next_freq_bad;
    end
  end

  // The system clock stands in for the main oscillator, so the divider never shifts delays
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pre     <= 5'h00;
      us_tick <= 1'b0;
    end else begin
      us_tick <= (pre == 5'(bcf_pkg::US_CYC - 1));
      pre     <= (pre == 5'(bcf_pkg::US_CYC - 1)) ? 5'h00 : pre + 5'h01;
    end
  end

  // Shared switching period counter, one count per oscillator cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pcnt <= 8'h00;
    end else begin
      pcnt <= (pcnt >= period - 8'h01) ? 8'h00 : pcnt + 8'h01;
    end
  end

  // Comparator output is asynchronous to this clock
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ov_s1 <= '0;
      ov_s2 <= '0;
    end else begin
      ov_s1 <= OV_TRIP;
      ov_s2 <= ov_s1;
    end
  end

  // Fault spreading to follower channels
  always_comb begin
    ov_kill = ov_s2;
    oc_kill = oc_now;
    for (int i = 0; i < NCH; i++) begin
      for (int j = 0; j < NCH; j++) begin
        if (FOLLOW[i*NCH+j] && ov_s2[i]) ov_kill[j] = 1'b1;
        if (FOLLOW[i*NCH+j] && oc_now[i]) oc_kill[j] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ov_lock <= '0;
    end else begin
      ov_lock <= (ov_lock & CH_EN) | ov_kill;
    end
  end

  // Sticky flags, a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      OV_FAULT <= '0;
      OC_FAULT <= '0;
    end else begin
      OV_FAULT <= (OV_FAULT & ~OV_CLR) | ov_s2;
      OC_FAULT <= (OC_FAULT & ~OC_CLR) | oc_now;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FAULT_GPIO <= 1'b0;
    end else begin
      FAULT_GPIO <= |(status & GPIO_MAP);
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [5:0]  lim;
    logic [1:0]  margin;
    logic [7:0]  warn_thr;
    logic [7:0]  isn;
    logic [17:0] tlim;
    logic        tdone;
    logic [7:0]  on_len;
    logic [7:0]  max_on;
    logic        hi_n;
    logic [7:0]  tgt;
    logic [7:0]  vout;
    logic [17:0] pg_lim;

    assign lim    = ILIM_CFG[i*8 + bcf_pkg::ILIM_LIM_LSB +: bcf_pkg::ILIM_LIM_W];
    assign margin = ILIM_CFG[i*8 + bcf_pkg::ILIM_MARGIN_LSB +: bcf_pkg::ILIM_MARGIN_W];
    assign isn    = ISENSE[i*8 +: 8];
    assign tgt    = VOUT_TARGET[i*8 +: 8];
    assign vout   = VOUT_ADC[i*8 +: 8];
    assign running[i] = !FREQ_BAD && (st[i] inside {bcf_pkg::ST_SS_RAMP, bcf_pkg::ST_ON,
                                                    bcf_pkg::ST_SD_DLY, bcf_pkg::ST_SD_RAMP});
    assign oc_now[i] = running[i] && (isn >= {2'b00, lim});
    assign pg_lim = 18'(PG_DLY[i*8 +: 8]) * 18'(bcf_pkg::DLY_STEP_US);

    // Margin is 10 mV per code step, floored at zero
    always_comb begin
      warn_thr = ({2'b00, lim} > 8'(bcf_pkg::MARGIN_STEP * (margin + 1))) ?
                 {2'b00, lim} - 8'(bcf_pkg::MARGIN_STEP * (margin + 1)) : 8'h00;
    end

    // Time limit for whatever the current state is waiting on
    always_comb begin
      unique case (st[i])
        bcf_pkg::ST_SS_DLY:
          tlim = 18'(SS_CFG[i*16 + bcf_pkg::RAMP_DLY_LSB +: bcf_pkg::RAMP_DLY_W]) *
                 18'(bcf_pkg::DLY_STEP_US);
        bcf_pkg::ST_SS_RAMP:
          tlim = 18'(SS_CFG[i*16 + bcf_pkg::RAMP_STEP_LSB +: bcf_pkg::RAMP_STEP_W]);
        bcf_pkg::ST_SD_DLY:
          tlim = 18'(SD_CFG[i*16 + bcf_pkg::RAMP_DLY_LSB +: bcf_pkg::RAMP_DLY_W]) *
                 18'(bcf_pkg::DLY_STEP_US);
        bcf_pkg::ST_SD_RAMP:
          tlim = 18'(SD_CFG[i*16 + bcf_pkg::RAMP_STEP_LSB +: bcf_pkg::RAMP_STEP_W]);
        bcf_pkg::ST_OC_WAIT: tlim = 18'(OC_RESTART_US);
        default: tlim = 18'h00000;
      endcase
    end
    assign tdone = us_tick && (cnt[i] + 18'h00001 >= tlim);

    // Channel sequencer
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        st[i]            <= bcf_pkg::ST_OFF;
        cnt[i]           <= 18'h00000;
        REF_CODE[i*8+:8] <= bcf_pkg::REF_RST;
      end else if (ov_kill[i]) begin
        st[i]            <= bcf_pkg::ST_OFF;
        cnt[i]           <= 18'h00000;
        REF_CODE[i*8+:8] <= bcf_pkg::REF_RST;
      end else if (oc_kill[i] && CH_EN[i] && !ov_lock[i] && st[i] != bcf_pkg::ST_OC_WAIT) begin
        st[i]            <= bcf_pkg::ST_OC_WAIT;
        cnt[i]           <= 18'h00000;
        REF_CODE[i*8+:8] <= bcf_pkg::REF_RST;
      end else begin
        cnt[i] <= tdone ? 18'h00000 : (us_tick ? cnt[i] + 18'h00001 : cnt[i]);
        unique case (st[i])
          bcf_pkg::ST_OFF: begin
            if (CH_EN[i] && !ov_lock[i]) begin
              st[i]  <= bcf_pkg::ST_SS_DLY;
              cnt[i] <= 18'h00000;
            end
          end
          bcf_pkg::ST_SS_DLY, bcf_pkg::ST_OC_WAIT: begin
            if (!CH_EN[i]) begin
              st[i] <= bcf_pkg::ST_OFF;
            end else if (tdone) begin
              st[i] <= (st[i] == bcf_pkg::ST_OC_WAIT) ? bcf_pkg::ST_SS_DLY :
                       bcf_pkg::ST_SS_RAMP;
            end
          end
          bcf_pkg::ST_SS_RAMP: begin
            if (!CH_EN[i]) begin
              st[i]  <= bcf_pkg::ST_SD_DLY;
              cnt[i] <= 18'h00000;
            end else if (tdone) begin
              if (REF_CODE[i*8+:8] >= tgt) st[i] <= bcf_pkg::ST_ON;
              else REF_CODE[i*8+:8] <= REF_CODE[i*8+:8] + 8'h01;
            end
          end
          bcf_pkg::ST_ON: begin
            REF_CODE[i*8+:8] <= tgt;
            if (!CH_EN[i]) begin
              st[i]  <= bcf_pkg::ST_SD_DLY;
              cnt[i] <= 18'h00000;
            end
          end
          bcf_pkg::ST_SD_DLY: begin
            if (tdone) st[i] <= bcf_pkg::ST_SD_RAMP;
          end
          bcf_pkg::ST_SD_RAMP: begin
            if (tdone) begin
              if (REF_CODE[i*8+:8] <= bcf_pkg::DISCH_REF) st[i] <= bcf_pkg::ST_OFF;
              else REF_CODE[i*8+:8] <= REF_CODE[i*8+:8] - 8'h01;
            end
          end
        endcase
      end
    end

    // Power-good delay only runs once the ramp has finished
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        pg_cnt[i] <= 18'h00000;
        PGOOD[i]  <= 1'b0;
      end else begin
        if (st[i] != bcf_pkg::ST_ON) pg_cnt[i] <= 18'h00000;
        else if (us_tick && pg_cnt[i] < pg_lim) pg_cnt[i] <= pg_cnt[i] + 18'h00001;
        PGOOD[i] <= (st[i] == bcf_pkg::ST_ON) && (pg_cnt[i] >= pg_lim) &&
                    (vout >= PG_MIN[i*8+:8]) && (vout <= PG_MAX[i*8+:8]);
      end
    end

    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        OC_WARN[i] <= 1'b0;
      end else begin
        OC_WARN[i] <= running[i] && (isn >= warn_thr);
      end
    end

    // On time is clamped; the low-side tail is kept for current sampling
    always_comb begin
      max_on = period - 8'(bcf_pkg::SAMPLE_CYC);
      on_len = DUTY[i*8+:8];
      if (on_len < 8'(bcf_pkg::MIN_ON_CYC)) on_len = 8'(bcf_pkg::MIN_ON_CYC);
      if (on_len > max_on) on_len = max_on;
      hi_n = running[i] && (pcnt < on_len);
    end

    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        GATE_HI[i] <= 1'b0;
        GATE_LO[i] <= 1'b0;
      end else begin
        GATE_HI[i] <= hi_n && !ov_kill[i];
        GATE_LO[i] <= (running[i] && !hi_n && !ov_kill[i]) ||
                      ((ov_lock[i] || ov_kill[i]) && OV_FORCED[i]);
      end
    end

    chk_ov_shutdown: assert property (ov_kill[i] |=> st[i] == bcf_pkg::ST_OFF && !GATE_HI[i])
      else $error("channel not shut down after over-voltage");
    chk_ov_hold_off: assert property (ov_lock[i] && CH_EN[i] |=> st[i] == bcf_pkg::ST_OFF)
      else $error("locked channel restarted without re-enable");
    chk_forced_low: assert property (ov_lock[i] && OV_FORCED[i] |=> GATE_LO[i])
      else $error("forced shutdown lost low-side drive");
    chk_passive_quiet: assert property (ov_lock[i] && !OV_FORCED[i] && !ov_kill[i]
                                        |=> !GATE_LO[i] && !GATE_HI[i])
      else $error("passive shutdown still pulsing");
    chk_warn_follow: assert property (##1 OC_WARN[i] == $past(running[i] &&
                                      ISENSE[i*8+:8] + 8'(2 * (margin + 1)) >= {2'b00, lim})
                                      || $past(warn_thr) == 8'h00)
      else $error("warning flag does not follow current");
    chk_oc_restart: assert property (oc_now[i] && CH_EN[i] && !ov_kill[i] && !ov_lock[i]
                                     |=> st[i] == bcf_pkg::ST_OC_WAIT ##1 !GATE_HI[i])
      else $error("over-current did not stop the channel");
    chk_oc_flag: assert property (oc_now[i] |=> OC_FAULT[i])
      else $error("over-current flag not set");
    chk_pg_after_ss: assert property (PGOOD[i] |-> $past(st[i]) == bcf_pkg::ST_ON)
      else $error("power good outside regulation state");
    chk_sample_tail: assert property (GATE_HI[i] |-> $past(pcnt) <
                                      $past(period) - 8'(bcf_pkg::SAMPLE_CYC))
      else $error("high side eats into sampling time");
    chk_no_early_pulse: assert property (GATE_HI[i] |-> $past(st[i]) != bcf_pkg::ST_SS_DLY)
      else $error("pulse during soft-start delay");

    cov_oc_cycle: cover property (st[i] == bcf_pkg::ST_OC_WAIT ##1 st[i] == bcf_pkg::ST_SS_DLY);
    cov_pg_rise: cover property ($rose(PGOOD[i]));
    cov_ramp_done: cover property (st[i] == bcf_pkg::ST_SS_RAMP ##1 st[i] == bcf_pkg::ST_ON);
    cov_ov_lock: cover property ($rose(ov_lock[i]) && OV_FORCED[i]);
  end

  chk_gpio_route: assert property (##1 FAULT_GPIO == $past(|(status & GPIO_MAP)))
    else $error("fault pin does not reflect selected flags");
  chk_div_zero: assert property (div_code == bcf_pkg::DIV_ILLEGAL |=> FREQ_BAD)
    else $error("divider code zero accepted");
endmodule : bcf_ctrl

// file: dv/bcf_plant.sv
// Power stage stand-in: output voltage, current sense and OV comparator
`timescale 1ns/1ps
module bcf_plant #(
  parameter int NCH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic [NCH*8-1:0] ref_code,
  input  wire logic [NCH*8-1:0] load,
  input  wire logic [NCH-1:0]   ov_inj,
  output logic      [NCH*8-1:0] isense,
  output logic      [NCH*8-1:0] vout_adc,
  output logic      [NCH-1:0]   ov_trip
);
  // Output follows the reference a cycle late; 50 mV codes become 20 mV codes
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NCH; i++) begin
      vout_adc[i*8 +: 8] <= 8'((int'(ref_code[i*8 +: 8]) * 5) / 2);
      // No inductor current while the reference sits at zero
      isense[i*8 +: 8] <= (ref_code[i*8 +: 8] != 8'h00) ? load[i*8 +: 8] : 8'h00;
    end
    ov_trip <= ov_inj;
  end
endmodule : bcf_plant

// file: dv/bcf_ctrl_tb.sv
// Self-checking bench for the buck channel control block
`timescale 1ns/1ps
module bcf_ctrl_tb;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  ch_en     = 4'h0;
  logic [3:0]  ov_forced = 4'h4;
  logic [3:0]  oc_clr    = 4'h0;
  logic [3:0]  ov_clr    = 4'h0;
  logic [3:0]  ov_inj    = 4'h0;
  logic [7:0]  freq_cfg  = 8'h01;
  logic [11:0] gpio_map  = 12'h010;
  logic [15:0] follow    = 16'h0802;
  logic [31:0] ilim      = {4{8'h14}};
  logic [31:0] vtgt      = {4{8'h04}};
  logic [31:0] pg_max    = {4{8'h14}};
  logic [31:0] pg_min    = {4{8'h02}};
  logic [31:0] pg_dly    = {4{8'h01}};
  logic [31:0] duty      = {4{8'h05}};
  logic [31:0] load      = 32'h0;
  logic [63:0] ss_cfg    = {4{16'h0402}};
  logic [63:0] sd_cfg    = {4{16'h0403}};
  wire  [3:0]  gate_hi, gate_lo, pgood, oc_fault, ov_fault, oc_warn, ov_trip;
  wire  [31:0] ref_code, isense, vout_adc;
  wire         fault_gpio, freq_bad;
  wire  [15:0] osc_khz;
  int          err_count = 0;
  int          compares  = 0;
  int          t;
  int          dv[3] = '{0, 5, 200};
  int          hv[3] = '{1, 5, 16};

  // Restart wait shortened so the run stays short
  bcf_ctrl #(.NCH(4), .OC_RESTART_US(50)) bcf_ctrl_i (
    .CLK_SYS(clk_sys), .RST(rst), .CH_EN(ch_en), .ILIM_CFG(ilim), .SS_CFG(ss_cfg),
    .SD_CFG(sd_cfg), .FREQ_CFG(freq_cfg), .VOUT_TARGET(vtgt), .PG_MAX(pg_max),
    .PG_MIN(pg_min), .PG_DLY(pg_dly), .FOLLOW(follow), .OV_FORCED(ov_forced),
    .GPIO_MAP(gpio_map), .OV_TRIP(ov_trip), .ISENSE(isense), .VOUT_ADC(vout_adc),
    .DUTY(duty), .OC_CLR(oc_clr), .OV_CLR(ov_clr), .GATE_HI(gate_hi), .GATE_LO(gate_lo),
    .REF_CODE(ref_code), .PGOOD(pgood), .OC_FAULT(oc_fault), .OV_FAULT(ov_fault),
    .OC_WARN(oc_warn), .FAULT_GPIO(fault_gpio), .OSC_KHZ(osc_khz), .FREQ_BAD(freq_bad));

  bcf_plant #(.NCH(4)) bcf_plant_i (
    .clk_sys(clk_sys), .ref_code(ref_code), .load(load), .ov_inj(ov_inj),
    .isense(isense), .vout_adc(vout_adc), .ov_trip(ov_trip));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  function automatic logic [7:0] probe(input int sel, input int ch);
    case (sel)
      0: probe = {7'h00, gate_hi[ch]};
      1: probe = {7'h00, pgood[ch]};
      2: probe = ref_code[ch*8 +: 8];
      default: probe = {7'h00, gate_lo[ch]};
    endcase
  endfunction : probe

  // Bounded wait, returns the cycles spent
  task automatic wait_for(input int sel, input int ch, input logic [7:0] v, output int n);
    n = 0;
    while (probe(sel, ch) !== v && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) chk("wait bound", 0, 1);
  endtask : wait_for

  task automatic count_hi(input int sel, input int ch, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge clk_sys);
      n += (probe(sel, ch) === 8'h01);
    end
  endtask : count_hi

  task automatic final_report();
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    // Scenarios need roughly 33k cycles; a hang ends well before the run limit
    cyc(60000);
    err_count++;
    final_report();
  end

  initial begin
    cyc(19);
    chk("osc in reset", 48000, osc_khz);
    // Reset sets the bad-frequency flag even though the divider code is one
    chk("gates in reset", 1, {gate_hi, gate_lo, freq_bad});
    cyc(1);
    rst = 1'b0;
    for (int o = 0; o < 8; o++) begin
      for (int d = 0; d < 8; d++) begin
        freq_cfg = {1'b0, o[2:0], 1'b0, d[2:0]};
        cyc(2);
        chk("osc khz", 48000 - 3200 * o, osc_khz);
        chk("freq bad", d == 0 || (48000 - 3200 * o) / (16 * (d + 1)) < 300, freq_bad);
      end
    end
    freq_cfg = 8'h01;
    ch_en = 4'h3;
    wait_for(0, 0, 8'h01, t);
    chk_rng("start delay", 4990, 5080, t);
    wait_for(2, 0, 8'h02, t);
    wait_for(2, 0, 8'h03, t);
    chk("rise step", 40, t);
    wait_for(2, 0, 8'h04, t);
    chk("pgood early", 0, pgood[0]);
    // Last ramp step (40 cycles) plus 250 us once regulating, plus the flag register
    wait_for(1, 0, 8'h01, t);
    chk_rng("pgood delay", 5030, 5050, t);
    pg_min[7:0] = 8'h0B;
    cyc(3);
    chk("pgood low bound", 0, pgood[0]);
    pg_min[7:0] = 8'h02;
    pg_max[7:0] = 8'h09;
    cyc(3);
    chk("pgood high bound", 0, pgood[0]);
    pg_max[7:0] = 8'h0A;
    cyc(3);
    chk("pgood edge", 1, pgood[0]);
    for (int k = 0; k < 3; k++) begin
      duty[7:0] = 8'(dv[k]);
      cyc(64);
      count_hi(0, 0, 32, t);
      chk("high cycles", hv[k], t);
      count_hi(3, 0, 32, t);
      chk("low cycles", 32 - hv[k], t);
    end
    freq_cfg = 8'h00;
    cyc(3);
    count_hi(0, 0, 64, t);
    chk("pulses on bad divider", 0, t);
    freq_cfg = 8'h01;
    for (int m = 0; m < 4; m++) begin
      ilim[7:0] = {m[1:0], 6'h14};
      load[7:0] = 8'(17 - 2 * m);
      cyc(3);
      chk("warn below", 0, oc_warn[0]);
      load[7:0] = 8'(18 - 2 * m);
      cyc(3);
      chk("warn at threshold", 1, oc_warn[0]);
    end
    load[7:0] = 8'h00;
    cyc(3);
    chk("warn self clear", 0, oc_warn[0]);
    ilim[7:0] = 8'h3F;
    load[7:0] = 8'h3E;
    cyc(3);
    chk("fault below limit", 0, oc_fault[0]);
    load[7:0] = 8'h3F;
    cyc(3);
    load[7:0] = 8'h00;
    chk("oc fault", 1, oc_fault[0]);
    chk("fault pin", 1, fault_gpio);
    count_hi(0, 1, 400, t);
    chk("follower stopped", 0, t);
    wait_for(0, 0, 8'h01, t);
    chk_rng("oc restart", 5550, 5700, t);
    wait_for(0, 1, 8'h01, t);
    chk_rng("follower restart", 0, 40, t);
    oc_clr = 4'h1;
    cyc(1);
    oc_clr = 4'h0;
    cyc(2);
    chk("fault cleared", 0, {oc_fault[0], fault_gpio});
    ch_en = 4'hF;
    wait_for(0, 2, 8'h01, t);
    ov_inj = 4'h4;
    cyc(6);
    ov_inj = 4'h0;
    chk("ov in soft-start", 1, ov_fault[2]);
    count_hi(0, 3, 300, t);
    chk("ov follower off", 0, t);
    count_hi(3, 2, 300, t);
    chk("forced low side", 300, t);
    count_hi(0, 2, 300, t);
    chk("ov stays off", 0, t);
    ov_clr = 4'h4;
    ch_en = 4'h3;
    cyc(1);
    ov_clr = 4'h0;
    ch_en = 4'hF;
    cyc(100);
    chk("low side released", 0, gate_lo[2]);
    wait_for(0, 3, 8'h01, t);
    chk_rng("follower re-enable", 4880, 4990, t);
    chk("ref at target", 4, ref_code[7:0]);
    // Slower divider: delays must not stretch with it
    freq_cfg = 8'h03;
    ch_en = 4'hE;
    wait_for(2, 0, 8'h03, t);
    chk_rng("stop delay", 4980, 5100, t);
    wait_for(2, 0, 8'h02, t);
    chk("fall step", 60, t);
    wait_for(2, 0, 8'h00, t);
    // Reaching zero takes one more step time before the channel is off
    cyc(64);
    count_hi(0, 0, 100, t);
    chk("off after stop", 0, t);
    final_report();
  end
endmodule : bcf_ctrl_tb
